/* rtl/iocn_port.sv */
// I/O port with open-drain select, analog pin config and input change notify.
// Assumes a single AHB-Lite master; pins and change inputs are synchronous to hclk.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
// Functional notes
// - A set open-drain bit makes that pin drive low only, never high.
// - An analog pin set as output still drives its latch level.
// - Analog pin config resets to zero, all shared pins analog.
// - Port reads return zero for every pin in analog mode.
// - A change on a selected input pin raises an interrupt request.
// - Change detection keeps working through sleep; changes are flagged while still asleep.
// - Up to twenty-one monitored change inputs.
// - Per-pin change enable bits, split over low and high registers.
// - Per-pin weak pull-up bits, split over low and high registers.
// - Any enabled interrupt source wakes the device from sleep.
module iocn_port import iocn_pkg::*; #(
   parameter int NPINS = PORT_W,
   parameter int NCN = CN_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [DATA_W-1:0] hrdata,
   input wire logic [NPINS-1:0] pad_in,
   output logic [NPINS-1:0] pad_out,
   output logic [NPINS-1:0] pad_oe,
   input wire logic [NCN-1:0] cn_in,
   output logic [NCN-1:0] pullup_en,
   input wire logic sleep_mode,
   output logic irq,
   output logic wake_req
);
   logic [NPINS-1:0] dir_reg, dir_next;
   logic [NPINS-1:0] lat_reg, lat_next;
   logic [NPINS-1:0] odc_reg, odc_next;
   logic [NPINS-1:0] apcfg_reg, apcfg_next;
   logic [NCN-1:0] cnen_reg, cnen_next;
   logic [NCN-1:0] cnpu_reg, cnpu_next;
   logic [NCN-1:0] mask_reg, mask_next;
   logic [NPINS-1:0] pad_out_reg, pad_out_next;
   logic [NPINS-1:0] pad_oe_reg, pad_oe_next;
   logic [NPINS-1:0] pin_smp_reg;
   logic [DATA_W-1:0] hrdata_reg, hrdata_next;
   logic hready_reg, hready_next;
   logic irq_reg, irq_next;
   logic wake_reg, wake_next;
   logic wr_reg, wr_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   iocn_bus_e st_reg, st_next;
   logic [NCN-1:0] pend;
   logic [NCN-1:0] pend_clr;
   logic accept;
   logic wr_dp;

   assign accept = hsel & hready & (htrans == HTRANS_NONSEQ);
   assign wr_dp = wr_reg;

   iocn_detect #(.N(NCN)) u_detect (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(cn_in),
      .enable(cnen_reg),
      .hold_ref(sleep_mode),
      .clear(pend_clr),
      .pending(pend)
   );

   // Bus front end: writes have no wait, reads one wait state so the data
   // reflects any write whose data phase overlapped the read's address phase.
   always_comb begin
      st_next = st_reg;
      hready_next = 1'b1;
      wr_next = 1'b0;
      addr_next = addr_reg;
      unique case (st_reg)
         ST_IDLE: begin
            if (accept) begin
               addr_next = haddr;
               if (hwrite) begin
                  wr_next = 1'b1;
               end else begin
                  st_next = ST_RDWAIT;
                  hready_next = 1'b0;
               end
            end
         end
         ST_RDWAIT: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_IDLE;
         hready_reg <= 1'b1;
         wr_reg <= 1'b0;
         addr_reg <= '0;
      end else begin
         st_reg <= st_next;
         hready_reg <= hready_next;
         wr_reg <= wr_next;
         addr_reg <= addr_next;
      end
   end

   // Register writes in the data phase; unmapped offsets are ignored
   always_comb begin
      dir_next = dir_reg;
      lat_next = lat_reg;
      odc_next = odc_reg;
      apcfg_next = apcfg_reg;
      cnen_next = cnen_reg;
      cnpu_next = cnpu_reg;
      mask_next = mask_reg;
      pend_clr = '0;
      if (wr_dp) begin
         case (addr_reg)
            OFF_DIR: dir_next = hwdata[NPINS-1:0];
            OFF_LAT, OFF_PORT: lat_next = hwdata[NPINS-1:0];
            OFF_ODC: odc_next = hwdata[NPINS-1:0];
            OFF_APCFG: apcfg_next = hwdata[NPINS-1:0];
            OFF_CNEN_LO: cnen_next[CN_LO_W-1:0] = hwdata[CN_LO_W-1:0];
            OFF_CNEN_HI: cnen_next[NCN-1:CN_LO_W] = hwdata[NCN-CN_LO_W-1:0];
            OFF_CNPU_LO: cnpu_next[CN_LO_W-1:0] = hwdata[CN_LO_W-1:0];
            OFF_CNPU_HI: cnpu_next[NCN-1:CN_LO_W] = hwdata[NCN-CN_LO_W-1:0];
            OFF_STATUS: pend_clr = hwdata[NCN-1:0];
            OFF_MASK: mask_next = hwdata[NCN-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_reg <= DIR_RST;
         lat_reg <= LAT_RST;
         odc_reg <= ODC_RST;
         apcfg_reg <= APCFG_RST;
         cnen_reg <= CNEN_RST;
         cnpu_reg <= CNPU_RST;
         mask_reg <= MASK_RST;
      end else begin
         dir_reg <= dir_next;
         lat_reg <= lat_next;
         odc_reg <= odc_next;
         apcfg_reg <= apcfg_next;
         cnen_reg <= cnen_next;
         cnpu_reg <= cnpu_next;
         mask_reg <= mask_next;
      end
   end

   // Read data, captured at the end of the read's wait state
   always_comb begin
      hrdata_next = hrdata_reg;
      if (st_reg == ST_RDWAIT) begin
         hrdata_next = '0;
         case (addr_reg)
            OFF_DIR: hrdata_next[NPINS-1:0] = dir_reg;
            OFF_LAT: hrdata_next[NPINS-1:0] = lat_reg;
            // Analog pins read low whatever the pad level
            OFF_PORT: hrdata_next[NPINS-1:0] = pin_smp_reg & apcfg_reg;
            OFF_ODC: hrdata_next[NPINS-1:0] = odc_reg;
            OFF_APCFG: hrdata_next[NPINS-1:0] = apcfg_reg;
            OFF_CNEN_LO: hrdata_next[CN_LO_W-1:0] = cnen_reg[CN_LO_W-1:0];
            OFF_CNEN_HI: hrdata_next[NCN-CN_LO_W-1:0] = cnen_reg[NCN-1:CN_LO_W];
            OFF_CNPU_LO: hrdata_next[CN_LO_W-1:0] = cnpu_reg[CN_LO_W-1:0];
            OFF_CNPU_HI: hrdata_next[NCN-CN_LO_W-1:0] = cnpu_reg[NCN-1:CN_LO_W];
            OFF_STATUS: hrdata_next[NCN-1:0] = pend;
            OFF_MASK: hrdata_next[NCN-1:0] = mask_reg;
            default: ;
         endcase
      end
   end

   // Pad drive; the analog setting never turns the driver off, so an
   // analog pin left as output converts its own driven level.
   always_comb begin
      pad_out_next = lat_reg & ~odc_reg;
      pad_oe_next = ~dir_reg & ~(odc_reg & lat_reg);
      irq_next = |(pend & mask_reg);
      wake_next = sleep_mode & irq_next;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= '0;
         pad_out_reg <= '0;
         pad_oe_reg <= '0;
         pin_smp_reg <= '0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         hrdata_reg <= hrdata_next;
         pad_out_reg <= pad_out_next;
         pad_oe_reg <= pad_oe_next;
         pin_smp_reg <= pad_in;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
      end
   end

   assign hreadyout = hready_reg;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_reg;
   assign pad_out = pad_out_reg;
   assign pad_oe = pad_oe_reg;
   assign pullup_en = cnpu_reg;
   assign irq = irq_reg;
   assign wake_req = wake_reg;

   a_od_never_high: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ((|($past(odc_reg) & pad_out_reg & pad_oe_reg)) == 1'b0))
      else $error("open-drain pin driven high");

   a_output_keeps_drive: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ((|(~$past(dir_reg) & ~$past(odc_reg) & ~pad_oe_reg)) == 1'b0))
      else $error("push-pull output pin not driven");

   a_apcfg_reset: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(!hresetn) |-> (apcfg_reg == APCFG_RST))
      else $error("analog config not zero after reset");

   a_analog_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_RDWAIT && addr_reg == OFF_PORT) |=> ((hrdata_reg[NPINS-1:0] & ~$past(apcfg_reg)) == '0))
      else $error("analog pin read as nonzero");

   a_port_read_sample: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_RDWAIT && addr_reg == OFF_PORT && apcfg_reg == '1)
      |=> (hrdata_reg[NPINS-1:0] == $past(pin_smp_reg)))
      else $error("port read not from sampled pins");

   a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (accept && !hwrite && st_reg == ST_IDLE) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(pend & mask_reg)) |=> irq)
      else $error("interrupt not raised for pending change");

   a_wake_on_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      (sleep_mode && (|(pend & mask_reg))) |=> wake_req)
      else $error("no wake request in sleep");

   a_irq_needs_source: assert property (@(posedge hclk) disable iff (!hresetn)
      irq |-> (|($past(pend) & $past(mask_reg))))
      else $error("interrupt raised with no unmasked pending flag");

   a_wake_needs_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
      wake_req |-> $past(sleep_mode))
      else $error("wake request raised while awake");

   a_od_high_released: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ((pad_oe_reg & $past(odc_reg) & $past(lat_reg)) == '0))
      else $error("open-drain pin with latch high still driven");
endmodule // iocn_port

/* rtl/iocn_pkg.sv */
// Constants shared by the I/O port and change-notify block.
// Assumes a 32-bit AHB-Lite slave with byte addresses of eight bits.
package iocn_pkg;
   localparam int PORT_W = 16;
   localparam int CN_W = 21;
   localparam int CN_LO_W = 16;
   localparam int CN_HI_W = CN_W - CN_LO_W;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_LAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PORT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_ODC = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_APCFG = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CNEN_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_CNEN_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_CNPU_LO = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_CNPU_HI = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h28;

   // Reset values
   localparam logic [PORT_W-1:0] DIR_RST = 16'hFFFF;
   localparam logic [PORT_W-1:0] LAT_RST = 16'h0000;
   localparam logic [PORT_W-1:0] ODC_RST = 16'h0000;
   localparam logic [PORT_W-1:0] APCFG_RST = 16'h0000;
   localparam logic [CN_W-1:0] CNEN_RST = 21'h000000;
   localparam logic [CN_W-1:0] CNPU_RST = 21'h000000;
   localparam logic [CN_W-1:0] MASK_RST = 21'h1FFFFF;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RDWAIT = 2'b10
   } iocn_bus_e;
endpackage

/* rtl/iocn_detect.sv */
// Per-pin change detector with sticky pending flags.
// Assumes pin levels are synchronous to hclk; clear mask is a one-cycle strobe.
`timescale 1ns/100ps
module iocn_detect import iocn_pkg::*; #(
   parameter int N = CN_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] enable,
   input wire logic hold_ref,
   input wire logic [N-1:0] clear,
   output logic [N-1:0] pending
);
   logic [N-1:0] ref_reg;
   logic [N-1:0] ref_next;
   logic [N-1:0] pend_reg;
   logic [N-1:0] pend_next;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         always_comb begin
            // Reference frozen while asleep, so a change then is flagged on the next clock, still asleep
            ref_next[i] = hold_ref ? ref_reg[i] : pin_in[i];
            // Set beats clear in the same cycle
            pend_next[i] = (enable[i] & (pin_in[i] ^ ref_reg[i])) | (pend_reg[i] & ~clear[i]);
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_reg <= '0;
         pend_reg <= '0;
      end else begin
         ref_reg <= ref_next;
         pend_reg <= pend_next;
      end
   end

   assign pending = pend_reg;

   // Checked per pin, so a flag already set elsewhere cannot hide a missed one
   a_change_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(enable & (pin_in ^ ref_reg))) |=> ((~pend_reg & $past(enable) & ($past(pin_in) ^ $past(ref_reg))) == '0))
      else $error("enabled pin change did not set pending flag");

   a_flag_stays_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(pend_reg & ~clear)) |=> ((~pend_reg & $past(pend_reg) & ~$past(clear)) == '0))
      else $error("pending flag dropped without a clear");

   a_masked_no_set: assert property (@(posedge hclk) disable iff (!hresetn)
      (|(~enable & ~pend_reg)) |=> ((pend_reg & ~$past(pend_reg) & ~$past(enable)) == '0))
      else $error("pending flag set on a disabled pin");
endmodule // iocn_detect

/* testbench/iocn_pins.sv */
// External pin model: resolves each port pad from the device drive and the board.
// Assumes a released pad sits at the board level given by ext_lvl.
`timescale 1ns/100ps
module iocn_pins import iocn_pkg::*; (
   input wire logic [PORT_W-1:0] pad_out,
   input wire logic [PORT_W-1:0] pad_oe,
   input wire logic [PORT_W-1:0] ext_lvl,
   output logic [PORT_W-1:0] pad_in
);
   // Released pins, open-drain or input, sit at the board level ext_lvl
   always_comb begin
      pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
   end
endmodule // iocn_pins

/* testbench/io_port_change_notify_tb.sv */
// Self-checking bench for the I/O port and change-notify block.
// Assumes one AHB-Lite master here and the pin model beside the port.
`timescale 1ns/100ps
module io_port_change_notify_tb import iocn_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic sleep_mode = 1'b0;
   logic [ADDR_W-1:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [DATA_W-1:0] hwdata = 32'h00000000;
   logic [DATA_W-1:0] hrdata;
   logic hreadyout, hresp, irq, wake_req;
   logic [PORT_W-1:0] pad_in, pad_out, pad_oe;
   logic [PORT_W-1:0] ext_lvl = 16'hFFFF;
   logic [CN_W-1:0] cn_in = 21'h000000;
   logic [CN_W-1:0] pullup_en;
   int n_errors = 0;
   int cmp_count = 0;

   always #20 hclk = ~hclk;

   iocn_port u_iocn_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .cn_in(cn_in), .pullup_en(pullup_en),
      .sleep_mode(sleep_mode), .irq(irq), .wake_req(wake_req));
   iocn_pins u_iocn_pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl), .pad_in(pad_in));

   task give_verdict;
      if (n_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Holds each phase until hready is seen high at a rising edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      chk(nm, e, q);
   endtask

   task tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   task t_reset;
      rd("dir", OFF_DIR, 32'h0000FFFF);
      rd("lat", OFF_LAT, 32'h00000000);
      rd("odc", OFF_ODC, 32'h00000000);
      rd("apcfg", OFF_APCFG, 32'h00000000);
      rd("cnen", OFF_CNEN_LO, 32'h00000000);
      rd("mask", OFF_MASK, 32'h001FFFFF);
      rd("unmapped", 8'h2C, 32'h00000000);
      chk("pad_oe", 32'h00000000, {16'h0000, pad_oe});
      chk("pullup", 32'h00000000, {11'h000, pullup_en});
   endtask

   task t_analog;
      wr(OFF_DIR, 32'h0000FFFF);
      rd("port analog", OFF_PORT, 32'h00000000);
      wr(OFF_APCFG, 32'h000000FF);
      rd("port mixed", OFF_PORT, 32'h000000FF);
   endtask

   task t_drive;
      wr(OFF_APCFG, 32'h0000FFFF);
      wr(OFF_DIR, 32'h00000000);
      wr(OFF_LAT, 32'h000000FF);
      wr(OFF_ODC, 32'h0000000F);
      tick(2);
      chk("pad_oe", 32'h0000FFF0, {16'h0000, pad_oe});
      chk("pad_out", 32'h000000F0, {16'h0000, pad_out});
      rd("port drive", OFF_PORT, 32'h000000FF);
      wr(OFF_PORT, 32'h0000000F);
      rd("lat via port", OFF_LAT, 32'h0000000F);
      wr(OFF_APCFG, 32'h00000000);
      tick(2);
      chk("pad_oe analog", 32'h0000FFF0, {16'h0000, pad_oe});
      rd("port analog out", OFF_PORT, 32'h00000000);
   endtask

   task t_change;
      wr(OFF_CNEN_LO, 32'h00000001);
      wr(OFF_CNEN_HI, 32'h00000010);
      rd("cnen hi", OFF_CNEN_HI, 32'h00000010);
      @(posedge hclk);
      cn_in <= 21'h000003;
      tick(3);
      chk("irq set", 32'h1, {31'h0, irq});
      rd("status", OFF_STATUS, 32'h00000001);
      @(posedge hclk);
      cn_in <= 21'h100003;
      tick(3);
      rd("status top", OFF_STATUS, 32'h00100001);
      wr(OFF_STATUS, 32'h00000001);
      rd("status w1c", OFF_STATUS, 32'h00100000);
      wr(OFF_MASK, 32'h000FFFFF);
      tick(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFF_STATUS, 32'h00100000);
      wr(OFF_MASK, 32'h001FFFFF);
      tick(2);
      chk("irq clear", 32'h0, {31'h0, irq});
   endtask

   task t_sleep;
      @(posedge hclk);
      sleep_mode <= 1'b1;
      @(posedge hclk);
      cn_in <= 21'h100002;
      tick(3);
      chk("wake", 32'h1, {31'h0, wake_req});
      @(posedge hclk);
      sleep_mode <= 1'b0;
      tick(2);
      rd("status sleep", OFF_STATUS, 32'h00000001);
      wr(OFF_STATUS, 32'h00000001);
      tick(2);
      chk("wake off", 32'h0, {31'h0, wake_req});
      chk("irq off", 32'h0, {31'h0, irq});
   endtask

   task t_pullup;
      // Change pins here are all inputs, so pull-ups are safe
      wr(OFF_CNPU_LO, 32'h0000A5A5);
      wr(OFF_CNPU_HI, 32'h00000015);
      tick(2);
      chk("pullup", 32'h0015A5A5, {11'h000, pullup_en});
      rd("cnpu hi", OFF_CNPU_HI, 32'h00000015);
   endtask

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_analog;
      t_drive;
      t_change;
      t_sleep;
      t_pullup;
      give_verdict;
   end

   // The whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge hclk);
      n_errors++;
      give_verdict;
   end
endmodule // io_port_change_notify_tb
